// >>> verilog/phy_mgmt_defines.svh
// offsets, field positions and reset values of the port management registers
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH
`define PORT_COUNT 5
`define PORT_ADDR_FIRST 5'h01
`define PORT_ADDR_LAST 5'h05
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h01
`define REG_ID_HIGH 5'h02
`define REG_ID_LOW 5'h03
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define CTL_SOFT_RESET 15
`define CTL_LOOPBACK 14
`define CTL_SPEED 13
`define CTL_AN_EN 12
`define CTL_POWER_DOWN 11
`define CTL_ISOLATE 10
`define CTL_AN_RESTART 9
`define CTL_FULL_DUPLEX 8
`define CTL_COL_TEST 7
`define CTL_FORCE_MDI 4
`define CTL_NO_AUTO_MDIX 3
`define CTL_NO_FEF 2
`define CTL_NO_TX 1
`define CTL_NO_LED 0
`define STS_T4 15
`define STS_CAPS_HI 14
`define STS_CAPS_LO 11
`define STS_PREAMBLE 6
`define STS_AN_DONE 5
`define STS_FEF 4
`define STS_AN_ABLE 3
`define STS_LINK 2
`define STS_JABBER 1
`define STS_EXT 0
`define STS_CAPS 4'hf
`define ADV_PAUSE 10
`define ABIL_HI 8
`define ABIL_LO 5
`define SEL_HI 4
`define SEL_LO 0
`define SELECTOR 5'h01
`define CTL_RST_SPEED 1'h1
`define CTL_RST_AN_EN 1'h1
`define ADV_RST_PAUSE 1'h1
`define ADV_RST_ABIL 4'hf
`endif

// >>> verilog/phy_mgmt_pkg.sv
// types shared by the port management register bank
package phy_mgmt_pkg;
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg_enable;
    logic power_down;
    logic autoneg_restart;
    logic full_duplex;
    logic force_mdi;
    logic no_auto_mdix;
    logic no_far_end_fault;
    logic no_transmit;
    logic no_led;
  } port_ctrl_t;
  typedef struct packed {
    logic link_up;
    logic autoneg_complete;
    logic far_end_fault;
    logic partner_pause;
    logic [3:0] partner_abil;
  } port_state_t;
  typedef struct packed {
    logic pause;
    logic [3:0] abil;
  } port_adv_t;
  typedef struct packed {
    logic write;
    logic [4:0] port_management_address;
    logic [4:0] register_index;
    logic [15:0] wdata;
  } mgmt_cmd_t;
  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_ANSWER = 1'b1
  } access_state_t;
endpackage

// >>> verilog/switch_port_phy_mgmt_regs.sv
// per-port transceiver management registers of a five-port switch
// Function
// - ports one to five answer addresses one-five
// - only register indexes zero to five exist
// - control bit 14 loops data back
// - control bit 13 selects 100 or 10
// - control bit 12 enables auto-negotiation
// - control bit 11 powers transceiver down
// - writing control bit 9 restarts negotiation
// - control bit 8 forces full duplex
// - control bit 4 forces straight MDI wiring
// - control bit 3 disables auto crossover
// - control bit 2 suppresses far-end fault detection
// - control bit 1 stops transmission
// - control bit 0 switches LEDs off
// - status capability bits 14-11 one, T4 zero
// - status bit 5 shows negotiation complete
// - status bit 4 shows far-end fault
// - status bit 3 one; bits 6,1,0 zero
// - registers 2,3 return fixed identifier
// - advertisement pause, abilities writable; selector 00001
// - partner register read-only, pause and abilities
`timescale 1ns/10ps
`include "phy_mgmt_defines.svh"
module switch_port_phy_mgmt_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h5a5a, // arbitrary value
  parameter logic [15:0] ID_LOW = 16'hc3c3 // arbitrary value
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic mgmt_req,
  input wire mgmt_cmd_t mgmt_cmd,
  output logic mgmt_ack,
  output logic mgmt_hit,
  output logic [15:0] mgmt_rdata,
  input wire port_state_t [4:0] port_state,
  input wire logic [4:0] restart_begun,
  output port_ctrl_t [4:0] port_ctrl,
  output port_adv_t [4:0] port_adv
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic addr_hit(input logic [4:0] a);
    return (a >= `PORT_ADDR_FIRST) && (a <= `PORT_ADDR_LAST);
  endfunction

  function automatic logic [2:0] slot(input logic [4:0] a);
    logic [4:0] d;
    d = a - `PORT_ADDR_FIRST;
    return d[2:0];
  endfunction

  function automatic logic [15:0] ctrl_word(input port_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`CTL_LOOPBACK] = c.loopback;
    w[`CTL_SPEED] = c.speed_100;
    w[`CTL_AN_EN] = c.autoneg_enable;
    w[`CTL_POWER_DOWN] = c.power_down;
    w[`CTL_AN_RESTART] = c.autoneg_restart;
    w[`CTL_FULL_DUPLEX] = c.full_duplex;
    w[`CTL_FORCE_MDI] = c.force_mdi;
    w[`CTL_NO_AUTO_MDIX] = c.no_auto_mdix;
    w[`CTL_NO_FEF] = c.no_far_end_fault;
    w[`CTL_NO_TX] = c.no_transmit;
    w[`CTL_NO_LED] = c.no_led;
    return w;
  endfunction

  localparam port_ctrl_t CTRL_RESET = '{
    loopback: 1'b0,
    speed_100: `CTL_RST_SPEED,
    autoneg_enable: `CTL_RST_AN_EN,
    power_down: 1'b0,
    autoneg_restart: 1'b0,
    full_duplex: 1'b0,
    force_mdi: 1'b0,
    no_auto_mdix: 1'b0,
    no_far_end_fault: 1'b0,
    no_transmit: 1'b0,
    no_led: 1'b0
  };

  localparam port_adv_t ADV_RESET = '{
    pause: `ADV_RST_PAUSE,
    abil: `ADV_RST_ABIL
  };

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  logic req_hit;
  logic [2:0] req_slot;
  logic [4:0] ctrl_wr;
  logic [4:0] adv_wr;

  assign req_hit = addr_hit(mgmt_cmd.port_management_address);
  assign req_slot = slot(mgmt_cmd.port_management_address);

  always_comb begin
    ctrl_wr = 5'h00;
    adv_wr = 5'h00;
    if (mgmt_req && mgmt_cmd.write && req_hit) begin
      if (mgmt_cmd.register_index == `REG_CONTROL) begin
        ctrl_wr[req_slot] = 1'b1;
      end
      // indexes other than control and advertisement are read-only or absent; writes fall away
      if (mgmt_cmd.register_index == `REG_ADVERT) begin
        adv_wr[req_slot] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // per-port storage
  // ------------------------------------------------------------
  port_ctrl_t [4:0] ctrl_reg;
  port_ctrl_t [4:0] ctrl_next;
  port_adv_t [4:0] adv_reg;
  port_state_t [4:0] state_reg;

  for (genvar p = 0; p < `PORT_COUNT; p++) begin : g_port
    always_comb begin
      ctrl_next[p] = ctrl_reg[p];
      if (ctrl_wr[p]) begin
        ctrl_next[p].loopback = mgmt_cmd.wdata[`CTL_LOOPBACK];
        ctrl_next[p].speed_100 = mgmt_cmd.wdata[`CTL_SPEED];
        ctrl_next[p].autoneg_enable = mgmt_cmd.wdata[`CTL_AN_EN];
        ctrl_next[p].power_down = mgmt_cmd.wdata[`CTL_POWER_DOWN];
        ctrl_next[p].full_duplex = mgmt_cmd.wdata[`CTL_FULL_DUPLEX];
        ctrl_next[p].force_mdi = mgmt_cmd.wdata[`CTL_FORCE_MDI];
        ctrl_next[p].no_auto_mdix = mgmt_cmd.wdata[`CTL_NO_AUTO_MDIX];
        ctrl_next[p].no_far_end_fault = mgmt_cmd.wdata[`CTL_NO_FEF];
        ctrl_next[p].no_transmit = mgmt_cmd.wdata[`CTL_NO_TX];
        ctrl_next[p].no_led = mgmt_cmd.wdata[`CTL_NO_LED];
      end
      // clear on start first, so a new request in the same cycle wins
      if (restart_begun[p]) begin
        ctrl_next[p].autoneg_restart = 1'b0;
      end
      if (ctrl_wr[p] && mgmt_cmd.wdata[`CTL_AN_RESTART]) begin
        ctrl_next[p].autoneg_restart = 1'b1;
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        ctrl_reg[p] <= CTRL_RESET;
      end else begin
        ctrl_reg[p] <= ctrl_next[p];
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        adv_reg[p] <= ADV_RESET;
      end else if (adv_wr[p]) begin
        adv_reg[p].pause <= mgmt_cmd.wdata[`ADV_PAUSE];
        adv_reg[p].abil <= mgmt_cmd.wdata[`ABIL_HI:`ABIL_LO];
      end
    end

    // transceiver status is sampled so link reads zero out of reset
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        state_reg[p] <= '0;
      end else begin
        state_reg[p] <= port_state[p];
      end
    end
  end

  assign port_ctrl = ctrl_reg;
  assign port_adv = adv_reg;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [15:0] read_word;

  always_comb begin
    read_word = 16'h0000;
    if (req_hit) begin
      case (mgmt_cmd.register_index)
        `REG_CONTROL: begin
          read_word = ctrl_word(ctrl_reg[req_slot]);
        end
        `REG_STATUS: begin
          read_word[`STS_CAPS_HI:`STS_CAPS_LO] = `STS_CAPS;
          read_word[`STS_AN_DONE] = state_reg[req_slot].autoneg_complete;
          read_word[`STS_FEF] = state_reg[req_slot].far_end_fault
            & ~ctrl_reg[req_slot].no_far_end_fault;
          read_word[`STS_AN_ABLE] = 1'b1;
          read_word[`STS_LINK] = state_reg[req_slot].link_up;
        end
        `REG_ID_HIGH: begin
          read_word = ID_HIGH;
        end
        `REG_ID_LOW: begin
          read_word = ID_LOW;
        end
        `REG_ADVERT: begin
          read_word[`ADV_PAUSE] = adv_reg[req_slot].pause;
          read_word[`ABIL_HI:`ABIL_LO] = adv_reg[req_slot].abil;
          read_word[`SEL_HI:`SEL_LO] = `SELECTOR;
        end
        `REG_PARTNER: begin
          read_word[`ADV_PAUSE] = state_reg[req_slot].partner_pause;
          read_word[`ABIL_HI:`ABIL_LO] = state_reg[req_slot].partner_abil;
        end
        default: begin
          read_word = 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // access sequencing
  // ------------------------------------------------------------
  access_state_t state_q;
  access_state_t state_d;
  logic hit_reg;
  logic [15:0] rdata_reg;

  always_comb begin
    unique case (state_q)
      ACC_IDLE: state_d = mgmt_req ? ACC_ANSWER : ACC_IDLE;
      ACC_ANSWER: state_d = mgmt_req ? ACC_ANSWER : ACC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ACC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hit_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (mgmt_req) begin
      hit_reg <= req_hit;
      rdata_reg <= mgmt_cmd.write ? 16'h0000 : read_word;
    end
  end

  assign mgmt_ack = (state_q == ACC_ANSWER);
  assign mgmt_hit = hit_reg;
  assign mgmt_rdata = rdata_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  mgmt_cmd_t cmd_seen;
  logic read_seen;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_seen <= '0;
      read_seen <= 1'b0;
    end else begin
      cmd_seen <= mgmt_cmd;
      read_seen <= mgmt_req && !mgmt_cmd.write;
    end
  end

  port_hit_a: assert property (@(posedge mclk) disable iff (!nrst)
    mgmt_req |=> mgmt_ack && (mgmt_hit == (cmd_seen.port_management_address >= 5'h01
      && cmd_seen.port_management_address <= 5'h05)))
    else $error("ack or address hit wrong");

  index_range_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && cmd_seen.register_index > 5'h05 |-> mgmt_rdata == 16'h0000)
    else $error("absent index read not zero");

  ctrl_fixed_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && cmd_seen.register_index == 5'h00
      |-> mgmt_rdata[15] == 1'b0 && mgmt_rdata[10] == 1'b0 && mgmt_rdata[7:5] == 3'h0)
    else $error("control fixed bits not zero");

  status_caps_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && mgmt_hit && cmd_seen.register_index == 5'h01
      |-> mgmt_rdata[15:11] == 5'h0f && mgmt_rdata[3] && mgmt_rdata[10:6] == 5'h00
        && mgmt_rdata[1:0] == 2'h0)
    else $error("status capability bits wrong");

  ident_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && mgmt_hit && cmd_seen.register_index == 5'h02 |-> mgmt_rdata == ID_HIGH)
    else $error("identifier high wrong");

  advert_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && mgmt_hit && cmd_seen.register_index == 5'h04
      |-> mgmt_rdata[4:0] == 5'h01 && mgmt_rdata[15:11] == 5'h00)
    else $error("advertisement selector wrong");

  partner_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    read_seen && cmd_seen.register_index == 5'h05
      |-> mgmt_rdata[15:11] == 5'h00 && mgmt_rdata[9] == 1'b0 && mgmt_rdata[4:0] == 5'h00)
    else $error("partner reserved bits not zero");

  for (genvar q = 0; q < `PORT_COUNT; q++) begin : g_chk
    ctrl_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_wr[q] |=> port_ctrl[q].loopback == cmd_seen.wdata[14]
        && port_ctrl[q].speed_100 == cmd_seen.wdata[13]
        && port_ctrl[q].autoneg_enable == cmd_seen.wdata[12]
        && port_ctrl[q].power_down == cmd_seen.wdata[11]
        && port_ctrl[q].full_duplex == cmd_seen.wdata[8])
      else $error("control write not taken");

    ctrl_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_wr[q] |=> {port_ctrl[q].force_mdi, port_ctrl[q].no_auto_mdix,
        port_ctrl[q].no_far_end_fault, port_ctrl[q].no_transmit, port_ctrl[q].no_led}
        == cmd_seen.wdata[4:0])
      else $error("control low bits not taken");

    restart_set_a: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_wr[q] && mgmt_cmd.wdata[9] |=> port_ctrl[q].autoneg_restart)
      else $error("restart not requested");

    restart_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
      restart_begun[q] && !ctrl_wr[q] |=> !port_ctrl[q].autoneg_restart)
      else $error("restart did not clear");

    link_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      mgmt_req && !mgmt_cmd.write && mgmt_cmd.register_index == 5'h01
        && mgmt_cmd.port_management_address == 5'(q + 1)
      |=> mgmt_rdata[2] == $past(state_reg[q].link_up)
        && mgmt_rdata[5] == $past(state_reg[q].autoneg_complete)
        && mgmt_rdata[4] == ($past(state_reg[q].far_end_fault)
          && !$past(ctrl_reg[q].no_far_end_fault)))
      else $error("status read does not follow port");
  end

endmodule

// >>> testbench/xcvr_model.sv
// transceiver-side model: starts a requested negotiation restart after a chosen delay
`timescale 1ns/10ps
module xcvr_model
  import phy_mgmt_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire port_ctrl_t [4:0] port_ctrl,
  input wire logic [3:0] delay,
  output logic [4:0] restart_begun
);
  logic [3:0] cnt [5];
  for (genvar p = 0; p < 5; p++) begin : g_port
    // one-cycle start pulse once the pending restart has waited delay cycles
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        cnt[p] <= 4'h0;
        restart_begun[p] <= 1'b0;
      end else if (port_ctrl[p].autoneg_restart && !restart_begun[p]) begin
        cnt[p] <= (cnt[p] == delay) ? 4'h0 : cnt[p] + 4'h1;
        restart_begun[p] <= (cnt[p] == delay);
      end else begin
        restart_begun[p] <= 1'b0;
      end
    end
  end
endmodule

// >>> testbench/test_switch_port_phy_mgmt_regs.sv
// self-checking bench for the port management register bank
`timescale 1ns/10ps
module test_switch_port_phy_mgmt_regs
  import phy_mgmt_pkg::*;
();
  logic mclk;
  logic nrst;
  logic mgmt_req;
  mgmt_cmd_t mgmt_cmd;
  logic mgmt_ack;
  logic mgmt_hit;
  logic [15:0] mgmt_rdata;
  port_state_t [4:0] port_state;
  logic [4:0] restart_begun;
  port_ctrl_t [4:0] port_ctrl;
  port_adv_t [4:0] port_adv;
  logic [3:0] delay;
  int error_cnt;
  int checks;
  localparam logic [15:0] IDH = 16'h1e2d; // arbitrary value
  localparam logic [15:0] IDL = 16'h4b3c; // arbitrary value

  switch_port_phy_mgmt_regs #(.ID_HIGH(IDH), .ID_LOW(IDL)) u_dut (.mclk(mclk), .nrst(nrst), .mgmt_req(mgmt_req),
    .mgmt_cmd(mgmt_cmd), .mgmt_ack(mgmt_ack), .mgmt_hit(mgmt_hit), .mgmt_rdata(mgmt_rdata),
    .port_state(port_state), .restart_begun(restart_begun), .port_ctrl(port_ctrl), .port_adv(port_adv));
  xcvr_model u_xcvr (.mclk(mclk), .nrst(nrst), .port_ctrl(port_ctrl), .delay(delay),
    .restart_begun(restart_begun));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic port_ctrl_t ctl(input logic [15:0] w);
    return '{w[14], w[13], w[12], w[11], w[9], w[8], w[4], w[3], w[2], w[1], w[0]};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic acc(input logic wr, input logic [4:0] a, input logic [4:0] i, input logic [15:0] wd,
                     input logic h, input logic [15:0] ex);
    mgmt_req = 1'b1;
    mgmt_cmd = {wr, a, i, wd};
    @(posedge mclk);
    #1 mgmt_req = 1'b0;
    // the ack stands only in the cycle after the request edge; hit and data hold until the next request
    chk("ack", 16'h1, {15'h0, mgmt_ack});
    chk("hit", {15'h0, h}, {15'h0, mgmt_hit});
    chk("rdata", ex, mgmt_rdata);
    @(posedge mclk);
    #1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] w;
    logic [4:0] m;
    nrst = 1'b0;
    mgmt_req = 1'b0;
    mgmt_cmd = '0;
    port_state = '0;
    delay = 4'h8;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(posedge mclk);
    #1 nrst = 1'b1;
    for (int p = 1; p <= 5; p++) begin
      chk("ctrl_out", 16'(ctl(16'h3000)), 16'(port_ctrl[p-1]));
      chk("adv_out", 16'h001f, 16'(port_adv[p-1]));
      acc(0, 5'(p), 5'h00, 16'h0, 1, 16'h3000);
      acc(0, 5'(p), 5'h01, 16'h0, 1, 16'h7808);
      acc(0, 5'(p), 5'h02, 16'h0, 1, IDH);
      acc(0, 5'(p), 5'h03, 16'h0, 1, IDL);
      acc(0, 5'(p), 5'h04, 16'h0, 1, 16'h05e1);
      acc(0, 5'(p), 5'h05, 16'h0, 1, 16'h0000);
      acc(1, 5'(p), 5'h06, 16'hffff, 1, 16'h0);
      acc(0, 5'(p), 5'h06, 16'h0, 1, 16'h0);
    end
    // address zero and addresses above five belong to no port
    for (int k = 0; k < 6; k++) begin
      m = (k == 5) ? 5'h1f : 5'(k * 6);
      acc(1, m, 5'h00, 16'hffff, 0, 16'h0);
      acc(0, m, 5'h00, 16'h0, 0, 16'h0);
    end
    for (int p = 1; p <= 5; p++) begin
      chk("ctrl_out", 16'(ctl(16'h3000)), 16'(port_ctrl[p-1]));
    end
    // walk each control bit except bit 9 on port 3, port 2 must keep reset values
    for (int b = 0; b < 16; b++) begin
      if (b != 9) begin
        w = 16'h1 << b;
        acc(1, 5'h03, 5'h00, w, 1, 16'h0);
        acc(0, 5'h03, 5'h00, 16'h0, 1, w & 16'h791f);
        chk("ctrl_bit", 16'(ctl(w & 16'h791f)), 16'(port_ctrl[2]));
        chk("ctrl_other", 16'(ctl(16'h3000)), 16'(port_ctrl[1]));
      end
    end
    for (int i = 1; i <= 5; i++) begin
      if (i != 4) begin
        acc(1, 5'h02, 5'(i), 16'hffff, 1, 16'h0);
      end
    end
    acc(0, 5'h02, 5'h01, 16'h0, 1, 16'h7808);
    acc(0, 5'h02, 5'h02, 16'h0, 1, IDH);
    acc(0, 5'h02, 5'h05, 16'h0, 1, 16'h0);
    acc(1, 5'h04, 5'h04, 16'hffff, 1, 16'h0);
    acc(0, 5'h04, 5'h04, 16'h0, 1, 16'h05e1);
    acc(1, 5'h04, 5'h04, 16'h0000, 1, 16'h0);
    acc(0, 5'h04, 5'h04, 16'h0, 1, 16'h0001);
    chk("adv_out", 16'h0000, 16'(port_adv[3]));
    // transceiver status seen through status and partner registers
    port_state[4] = '{1'b1, 1'b1, 1'b1, 1'b1, 4'ha};
    // status flops must take the new levels one edge before the read
    @(posedge mclk);
    #1;
    acc(0, 5'h05, 5'h01, 16'h0, 1, 16'h783c);
    acc(0, 5'h05, 5'h05, 16'h0, 1, 16'h0540);
    acc(0, 5'h04, 5'h01, 16'h0, 1, 16'h7808);
    acc(1, 5'h05, 5'h00, 16'h3004, 1, 16'h0);
    acc(0, 5'h05, 5'h01, 16'h0, 1, 16'h782c);
    port_state[4] = '0;
    @(posedge mclk);
    #1;
    acc(0, 5'h05, 5'h01, 16'h0, 1, 16'h7808);
    // restart with a slow and a prompt transceiver
    for (int d = 0; d < 2; d++) begin
      delay = d ? 4'h0 : 4'h8;
      acc(1, 5'h01, 5'h00, 16'h3200, 1, 16'h0);
      chk("restart_out", 16'h1, {15'h0, port_ctrl[0].autoneg_restart});
      if (d == 0) begin
        acc(0, 5'h01, 5'h00, 16'h0, 1, 16'h3200);
      end
      for (int t = 0; t < 20 && port_ctrl[0].autoneg_restart !== 1'b0; t++) @(posedge mclk);
      #1;
      chk("restart_out", 16'h0, {15'h0, port_ctrl[0].autoneg_restart});
      acc(0, 5'h01, 5'h00, 16'h0, 1, 16'h3000);
    end
    finish_test();
  end
endmodule
